// ### hw/ioxp_defs.vh
// Register map, field positions and reset values of the expander port.
`ifndef IOXP_DEFS_VH
`define IOXP_DEFS_VH

`define IOXP_ADDR_DIR      8'h00
`define IOXP_ADDR_PIN_EN   8'h02
`define IOXP_ADDR_DEFVAL   8'h03
`define IOXP_ADDR_CMPSEL   8'h04
`define IOXP_ADDR_CONFIG   8'h05
`define IOXP_ADDR_PULLUP   8'h06
`define IOXP_ADDR_FLAGS    8'h07
`define IOXP_ADDR_CAPTURE  8'h08
`define IOXP_ADDR_PORT     8'h09
`define IOXP_ADDR_LATCH    8'h0a
`define IOXP_ADDR_LAST     8'h0a

`define IOXP_CFG_SEQ_DIS   5
`define IOXP_CFG_SLEW      4
`define IOXP_CFG_HA_EN     3
`define IOXP_CFG_OD_SEL    2
`define IOXP_CFG_POL       1
`define IOXP_CFG_WMASK     8'hfe

`define IOXP_RST_ZERO      8'h00
`define IOXP_RST_DIR       8'hff
`define IOXP_PTR_STEP      8'h01
`define IOXP_HW_ADDR_ZERO  3'h0
`endif

// ### hw/ioxp_irq_out.v
// Interrupt output pin driver: open-drain or push-pull with polarity.
`timescale 1ns/10ps
`include "ioxp_defs.vh"
module ioxp_irq_out (
    input wire core_clk_i,   // Core clock.
    input wire rst_i,        // Synchronous reset, active high.
    input wire pending_i,    // Interrupt pending level.
    input wire od_sel_i,     // Open-drain select.
    input wire polarity_i,   // Active level when driven.
    output reg irq_o,        // Pin output value.
    output reg irq_oe_o      // Pin output enable.
);
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b1;
            irq_oe_o <= 1'b1;
        end else if (od_sel_i) begin
            // Open-drain pulls low only while pending.
            irq_o <= 1'b0;
            irq_oe_o <= pending_i;
        end else begin
            irq_o <= polarity_i ? pending_i : ~pending_i;
            irq_oe_o <= 1'b1;
        end
    end
endmodule

// ### hw/ioxp_port.v
// One 8-bit expander port: register file, interrupt capture and pin control.
`timescale 1ns/10ps
`include "ioxp_defs.vh"
module ioxp_port (
    input wire core_clk_i,        // Core clock, 100 MHz.
    input wire rst_i,             // Synchronous reset, active high.
    input wire is_spi_i,          // High on the SPI variant.
    input wire [2:0] addr_pins_i, // Hardware address pins.
    input wire [7:0] pins_i,      // Present port pin levels.
    input wire addr_load_i,       // Pulse: load register pointer.
    input wire [7:0] addr_i,      // Register address to load.
    input wire wr_i,              // Pulse: write data byte.
    input wire [7:0] wdata_i,     // Write data byte.
    input wire rd_i,              // Pulse: fetch read byte.
    input wire rd_done_i,         // Pulse: last read bit shifted out.
    output reg [7:0] rdata_o,     // Read data byte.
    output reg [7:0] pins_o,      // Pin output values.
    output reg [7:0] pins_oe_o,   // Pin output enables.
    output reg [7:0] pullup_o,    // Weak pull-up enables.
    output reg [2:0] hw_addr_o,   // Effective device address.
    output reg slew_ctrl_o,       // Slew control for serial data.
    output reg [7:0] ptr_o,       // Current register pointer.
    output reg irq_out_first_port_o,   // Interrupt pin value.
    output reg irq_out_first_port_oe_o // Interrupt pin enable.
);
    reg [7:0] dir_r;
    reg [7:0] pin_irq_enable_r;
    reg [7:0] defval_r;
    reg [7:0] cmpsel_r;
    reg [7:0] expander_config_r;
    reg [7:0] pullup_enable_r;
    reg [7:0] interrupt_flags_r;
    reg [7:0] interrupt_capture_r;
    reg [7:0] output_latch_r;
    reg [7:0] prev_pins_r;
    reg [7:0] ptr_r;
    reg pending_r;
    reg clr_src_r;
    reg [7:0] ptr_nxt;
    reg [7:0] rd_mux;
    wire [7:0] cause;
    wire irq_pin;
    wire irq_pin_oe;
    wire clear_now;
    wire auto_increment_disable;
    wire hw_address_enable;
    wire irq_open_drain_sel;
    wire irq_polarity;

    // True when the pointer addresses a given register.
    function is_addr;
        input [7:0] ptr;
        input [7:0] target;
        begin
            is_addr = (ptr == target);
        end
    endfunction

    assign auto_increment_disable = expander_config_r[`IOXP_CFG_SEQ_DIS];
    assign hw_address_enable = expander_config_r[`IOXP_CFG_HA_EN];
    assign irq_open_drain_sel = expander_config_r[`IOXP_CFG_OD_SEL];
    assign irq_polarity = expander_config_r[`IOXP_CFG_POL];

    // Only enabled input pins compare, against default or previous level.
    assign cause = pin_irq_enable_r & dir_r &
                   (pins_i ^ ((cmpsel_r & defval_r) |
                              (~cmpsel_r & prev_pins_r)));
    assign clear_now = rd_done_i & clr_src_r;

    ////////////////////////////////////////////////////////////////////
    // Register pointer.
    always @* begin
        ptr_nxt = ptr_r;
        if (addr_load_i) begin
            ptr_nxt = addr_i;
        end else if ((wr_i | rd_i) && !auto_increment_disable) begin
            ptr_nxt = (ptr_r == `IOXP_ADDR_LAST) ? `IOXP_RST_ZERO :
                      ptr_r + `IOXP_PTR_STEP;
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            ptr_r <= `IOXP_RST_ZERO;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes. Flags and capture have no write path at all.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            dir_r <= `IOXP_RST_DIR;
            pin_irq_enable_r <= `IOXP_RST_ZERO;
            defval_r <= `IOXP_RST_ZERO;
            cmpsel_r <= `IOXP_RST_ZERO;
            expander_config_r <= `IOXP_RST_ZERO;
            pullup_enable_r <= `IOXP_RST_ZERO;
            output_latch_r <= `IOXP_RST_ZERO;
        end else if (wr_i) begin
            if (is_addr(ptr_r, `IOXP_ADDR_DIR))
                dir_r <= wdata_i;
            if (is_addr(ptr_r, `IOXP_ADDR_PIN_EN))
                pin_irq_enable_r <= wdata_i;
            if (is_addr(ptr_r, `IOXP_ADDR_DEFVAL))
                defval_r <= wdata_i;
            if (is_addr(ptr_r, `IOXP_ADDR_CMPSEL))
                cmpsel_r <= wdata_i;
            if (is_addr(ptr_r, `IOXP_ADDR_CONFIG))
                expander_config_r <= wdata_i & `IOXP_CFG_WMASK;
            if (is_addr(ptr_r, `IOXP_ADDR_PULLUP))
                pullup_enable_r <= wdata_i;
            if (is_addr(ptr_r, `IOXP_ADDR_PORT) ||
                    is_addr(ptr_r, `IOXP_ADDR_LATCH))
                output_latch_r <= wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt capture. A clear in the same cycle as a new cause lets
    // the new event take over, so a cause still present at the clear is not lost.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pending_r <= 1'b0;
            interrupt_flags_r <= `IOXP_RST_ZERO;
            interrupt_capture_r <= `IOXP_RST_ZERO;
            prev_pins_r <= `IOXP_RST_ZERO;
            clr_src_r <= 1'b0;
        end else begin
            if (rd_i)
                clr_src_r <= is_addr(ptr_r, `IOXP_ADDR_PORT) ||
                             is_addr(ptr_r, `IOXP_ADDR_CAPTURE);
            else if (rd_done_i)
                clr_src_r <= 1'b0;
            if ((!pending_r || clear_now) && |cause) begin
                pending_r <= 1'b1;
                interrupt_flags_r <= cause;
                interrupt_capture_r <= pins_i;
            end else if (clear_now) begin
                pending_r <= 1'b0;
                interrupt_flags_r <= `IOXP_RST_ZERO;
            end
            // Previous level is re-armed only while nothing is pending or a clear is taken.
            if (!pending_r || clear_now)
                prev_pins_r <= pins_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data and pin outputs.
    always @* begin
        case (ptr_r)
            `IOXP_ADDR_DIR: rd_mux = dir_r;
            `IOXP_ADDR_PIN_EN: rd_mux = pin_irq_enable_r;
            `IOXP_ADDR_DEFVAL: rd_mux = defval_r;
            `IOXP_ADDR_CMPSEL: rd_mux = cmpsel_r;
            `IOXP_ADDR_CONFIG: rd_mux = expander_config_r;
            `IOXP_ADDR_PULLUP: rd_mux = pullup_enable_r;
            `IOXP_ADDR_FLAGS: rd_mux = interrupt_flags_r;
            `IOXP_ADDR_CAPTURE: rd_mux = interrupt_capture_r;
            `IOXP_ADDR_PORT: rd_mux = pins_i;
            `IOXP_ADDR_LATCH: rd_mux = output_latch_r;
            default: rd_mux = `IOXP_RST_ZERO;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o <= `IOXP_RST_ZERO;
            pins_o <= `IOXP_RST_ZERO;
            pins_oe_o <= `IOXP_RST_ZERO;
            pullup_o <= `IOXP_RST_ZERO;
            hw_addr_o <= `IOXP_HW_ADDR_ZERO;
            slew_ctrl_o <= 1'b0;
            ptr_o <= `IOXP_RST_ZERO;
        end else begin
            if (rd_i)
                rdata_o <= rd_mux;
            pins_o <= output_latch_r;
            pins_oe_o <= ~dir_r;
            pullup_o <= pullup_enable_r & dir_r;
            hw_addr_o <= (!is_spi_i || hw_address_enable) ?
                         addr_pins_i : `IOXP_HW_ADDR_ZERO;
            slew_ctrl_o <= ~expander_config_r[`IOXP_CFG_SLEW];
            ptr_o <= ptr_nxt;
        end
    end

    ioxp_irq_out u_irq (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pending_i(pending_r),
        .od_sel_i(irq_open_drain_sel),
        .polarity_i(irq_polarity),
        .irq_o(irq_pin),
        .irq_oe_o(irq_pin_oe)
    );

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_out_first_port_o <= 1'b1;
            irq_out_first_port_oe_o <= 1'b1;
        end else begin
            irq_out_first_port_o <= irq_pin;
            irq_out_first_port_oe_o <= irq_pin_oe;
        end
    end
endmodule

// ### verif/ioxp_port_properties.sv
// Concurrent checks on the expander port's registers and pins.
`timescale 1ns/10ps
module ioxp_port_properties (
    input wire core_clk_i, // Clock.
    input wire rst_i, // Reset.
    input wire is_spi_i, // Variant.
    input wire [2:0] addr_pins_i, // Strap.
    input wire [7:0] pins_i, // Levels.
    input wire addr_load_i, // Load.
    input wire [7:0] addr_i, // Address.
    input wire wr_i, // Write.
    input wire [7:0] wdata_i, // Byte.
    input wire rd_i, // Read.
    input wire [7:0] rdata_o, // Byte.
    input wire [7:0] pins_o, // Latch.
    input wire [7:0] pins_oe_o, // Enables.
    input wire [7:0] pullup_o, // Pull-ups.
    input wire [2:0] hw_addr_o, // Address.
    input wire slew_ctrl_o, // Slew.
    input wire [7:0] ptr_o // Pointer.
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    ptr_load_a: assert property (addr_load_i |=> ptr_o == $past(addr_i))
        else $error("pointer load lost");
    ptr_step_a: assert property ((wr_i || rd_i) && !addr_load_i |=>
        ptr_o == $past(ptr_o) ||
        ptr_o == ($past(ptr_o) == 8'h0a ? 8'h00 : $past(ptr_o) + 8'h01))
        else $error("pointer step wrong");
    port_read_a: assert property (rd_i && ptr_o == 8'h09 |=> rdata_o == $past(pins_i))
        else $error("port read not pin levels");
    port_write_a: assert property (wr_i && ptr_o == 8'h09 |-> ##2 pins_o == $past(wdata_i, 2))
        else $error("port write missed latch");
    pullup_input_a: assert property ((pullup_o & pins_oe_o) == 8'h00)
        else $error("pull-up on output pin");
    hw_addr_a: assert property (!$past(rst_i) && !$past(is_spi_i) |-> hw_addr_o == $past(addr_pins_i))
        else $error("two-wire address not pins");
    cfg_slew_a: assert property (wr_i && ptr_o == 8'h05 |-> ##2 slew_ctrl_o != $past(wdata_i[4], 2))
        else $error("config slew bit wrong");
    flag_wr_a: assert property (wr_i && ptr_o == 8'h07 |-> ##2 $stable(pins_o) && $stable(pins_oe_o) && $stable(pullup_o))
        else $error("flag write changed state");
    cap_wr_a: assert property (wr_i && ptr_o == 8'h08 |-> ##2 $stable(pins_o) && $stable(slew_ctrl_o))
        else $error("capture write changed state");
endmodule
bind ioxp_port ioxp_port_properties u_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .is_spi_i(is_spi_i), .addr_pins_i(addr_pins_i), .pins_i(pins_i),
    .addr_load_i(addr_load_i), .addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pins_o(pins_o), .pins_oe_o(pins_oe_o),
    .pullup_o(pullup_o), .hw_addr_o(hw_addr_o), .slew_ctrl_o(slew_ctrl_o),
    .ptr_o(ptr_o));

// ### verif/ioxp_host_model.sv
// Host controller model that issues the serial register strobes.
`timescale 1ns/10ps
module ioxp_host_model (
    input wire core_clk_i, // Clock.
    input wire [7:0] rdata_i, // Read byte.
    output logic addr_load_o, // Load.
    output logic [7:0] addr_o, // Address.
    output logic wr_o, // Write.
    output logic [7:0] wdata_o, // Byte.
    output logic rd_o, // Read.
    output logic rd_done_o // Last bit out.
);
    initial begin
        {addr_load_o, wr_o, rd_o, rd_done_o} = 4'h0;
        {addr_o, wdata_o} = 16'h0000;
    end
    // Released lines flip, so a stale value is never mistaken for fresh.
    task automatic load(input logic [7:0] a);
        @(posedge core_clk_i) #1;
        {addr_load_o, addr_o} = {1'b1, a};
        @(posedge core_clk_i) #1;
        {addr_load_o, addr_o} = {1'b0, ~a};
    endtask
    task automatic put(input logic [7:0] d);
        @(posedge core_clk_i) #1;
        {wr_o, wdata_o} = {1'b1, d};
        @(posedge core_clk_i) #1;
        {wr_o, wdata_o} = {1'b0, ~d};
    endtask
    // The lag stands for a slow shift of the byte before its last bit.
    task automatic get(output logic [7:0] q, input int lag);
        @(posedge core_clk_i) #1;
        rd_o = 1'b1;
        @(posedge core_clk_i) #1;
        rd_o = 1'b0;
        q = rdata_i;
        repeat (lag) @(posedge core_clk_i);
        @(posedge core_clk_i) #1;
        rd_done_o = 1'b1;
        @(posedge core_clk_i) #1;
        rd_done_o = 1'b0;
    endtask
endmodule

// ### verif/ioxp_port_bench.sv
// Self-checking bench for one expander port driven by a host model.
`timescale 1ns/10ps
module ioxp_port_bench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg spi = 1'b1;
    reg [7:0] pins = 8'h00;
    wire ld, wr, rd, rdone, slew, irq, irq_oe;
    wire [7:0] addr, wdata, rdata, lat, oe, pu, ptr;
    wire [2:0] hwa;
    int errors = 0;
    int samples_checked = 0;
    logic [7:0] q;
    logic [7:0] cv [5] = '{8'h00, 8'h02, 8'h04, 8'h0e, 8'h18};
    logic [7:0] ev [5] = '{8'he0, 8'ha0, 8'h20, 8'h25, 8'hc5};
    always #5 clk = ~clk;
    ioxp_port dut (.core_clk_i(clk), .rst_i(rst), .is_spi_i(spi),
        .addr_pins_i(3'h5), .pins_i(pins), .addr_load_i(ld), .addr_i(addr),
        .wr_i(wr), .wdata_i(wdata), .rd_i(rd), .rd_done_i(rdone),
        .rdata_o(rdata), .pins_o(lat), .pins_oe_o(oe), .pullup_o(pu),
        .hw_addr_o(hwa), .slew_ctrl_o(slew), .ptr_o(ptr),
        .irq_out_first_port_o(irq), .irq_out_first_port_oe_o(irq_oe));
    ioxp_host_model h (.core_clk_i(clk), .rdata_i(rdata), .addr_load_o(ld),
        .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd), .rd_done_o(rdone));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        h.load(a);
        h.put(d);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        h.load(a);
        h.get(q, 0);
        chk(q, e);
    endtask
    task automatic t_reset;
        chk({oe | pu, irq, irq_oe}, {8'h00, 2'b11});
        rreg(8'h06, 8'h00);
        rreg(8'h07, 8'h00);
        rreg(8'h01, 8'h00);
    endtask
    task automatic t_port;
        wreg(8'h00, 8'h0f);
        wreg(8'h09, 8'ha5);
        wreg(8'h06, 8'hff);
        settle(2);
        chk(lat, 8'ha5);
        chk(pu & ~oe, 8'h0f);
        rreg(8'h0a, 8'ha5);
        pins = 8'h3c;
        rreg(8'h09, 8'h3c);
        wreg(8'h07, 8'hff);
        rreg(8'h07, 8'h00);
        wreg(8'h00, 8'hff);
    endtask
    task automatic t_cfg;
        for (int i = 0; i < 5; i++) begin
            wreg(8'h05, cv[i]);
            settle(3);
            chk({irq_oe, irq & irq_oe, slew, 2'b00, hwa}, ev[i]);
            rreg(8'h05, cv[i]);
        end
        spi = 1'b0;
        wreg(8'h05, 8'h00);
        settle(3);
        chk({5'h00, hwa}, 8'h05);
    endtask
    task automatic t_irq;
        pins = 8'h00;
        wreg(8'h05, 8'h02);
        wreg(8'h02, 8'h81);
        pins = 8'h01;
        settle(4);
        chk({7'h00, irq}, 8'h01);
        rreg(8'h07, 8'h01);
        pins = 8'h81;
        wreg(8'h08, 8'hff);
        wreg(8'h09, 8'h00);
        settle(4);
        chk({7'h00, irq}, 8'h01);
        rreg(8'h07, 8'h01);
        pins = 8'h01;
        rreg(8'h08, 8'h01);
        settle(4);
        chk({7'h00, irq}, 8'h00);
        rreg(8'h07, 8'h00);
        wreg(8'h05, 8'h22);
        h.load(8'h09);
        pins = 8'h5b;
        h.get(q, 0);
        h.get(q, 2);
        chk(q, 8'h5b);
        chk(ptr, 8'h09);
    endtask
    // Default-compare source with an open-drain pin; the mismatch outlives
    // a capture read, so the interrupt must come straight back.
    task automatic t_defcmp;
        wreg(8'h05, 8'h04);
        wreg(8'h03, 8'h80);
        wreg(8'h04, 8'h80);
        settle(4);
        chk({6'h00, irq_oe, irq}, 8'h02);
        rreg(8'h08, 8'h5b);
        rreg(8'h07, 8'h80);
        pins = 8'hdb;
        rreg(8'h09, 8'hdb);
        settle(4);
        chk({6'h00, irq_oe, irq}, 8'h00);
        rreg(8'h07, 8'h00);
    endtask
    task automatic finish_test;
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        settle(3);
        rst = 1'b0;
        t_reset;
        t_port;
        t_cfg;
        t_irq;
        t_defcmp;
        finish_test;
    end
    initial begin
        #50000;
        errors++;
        finish_test;
    end
endmodule
